// ### pzc_top.sv
// AXI4-Lite register bank for impedance status and byte-lane configuration
// Operation
// [RULE1] Pull-down drive status: 0 ok, 1 overflow, 2 underflow, 3 busy.
// [RULE2] Pull-up drive status in result bits 3:2, same codes.
// [RULE3] Termination pull-down status in result bits 5:4, same codes.
// [RULE4] Termination pull-up status in result bits 7:6, same codes.
// [RULE5] Result register read-only, resets zero, bits 31:8 read zero.
// [RULE6] Status registers exist once per segment, four segments.
// [RULE7] Lane configuration exists once per lane, nine lanes, independent.
// [RULE8] Skip bit 31 (reset 0) stops automatic measurement after init.
// [RULE9] Enable bit 30 (reset 1) keeps repeated filtered measurements running.
// [RULE10] Initial measurement after init or trigger; continue needs lane AND common.
// [RULE11] Bits 29:26 (reset all ones) enable leveling, bit i for rank i.
// [RULE12] Disabled ranks: responses ignored, leveling flagged done.
// [RULE13] Lane bits 25:20 read-only zero.
// [RULE14] Main status: done bit 31, error bit 30, read-only, reset zero.
// [RULE15] Status follows engine continuously; reads harmless, read-only writes ignored.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pzc_top
  import pzc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [`PZC_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [`PZC_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [`PZC_SEG_N-1:0] i_zq_done,
  input wire logic [`PZC_SEG_N-1:0] i_zq_err,
  input wire logic [`PZC_SEG_N*`PZC_RES_W-1:0] i_zq_state,
  input wire logic i_init_done,
  input wire logic i_cal_trigger,
  input wire logic i_common_mdl_en,
  input wire logic [`PZC_LANE_N-1:0] i_meas_done,
  input wire logic [`PZC_LANE_N*`PZC_RANK_N-1:0] i_wl_resp,
  output logic [`PZC_LANE_N-1:0] o_meas_start,
  output logic [`PZC_LANE_N-1:0] o_mdl_cont,
  output logic [`PZC_LANE_N*`PZC_RANK_N-1:0] o_wl_done,
  output logic [`PZC_LANE_N*`PZC_RANK_N-1:0] o_wl_resp,
  output logic o_irq
);
  // Status copies
  logic [`PZC_SEG_N-1:0] done_r, done_nxt, err_r, err_nxt;
  logic [`PZC_RES_W-1:0] res_r [`PZC_SEG_N], res_nxt [`PZC_SEG_N];
  // Software state
  pzc_lane_cfg_t cfg_r [`PZC_LANE_N], cfg_nxt [`PZC_LANE_N];
  logic [`PZC_INT_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev, w1c;
  logic irq_r, irq_nxt;
  logic [`PZC_LANE_N-1:0] lane_run;
  // Bus state
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt, bvalid_r, bvalid_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt, do_wr;
  logic [`PZC_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt, rd_word;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt, rd_resp;
  logic [`PZC_ADDR_W-1:0] rd_addr_r, rd_addr_nxt;

  // Word index of an aligned address inside a block of n words, or -1 outside or unaligned
  function automatic int pzc_slot(input logic [`PZC_ADDR_W-1:0] addr,
                                  input logic [`PZC_ADDR_W-1:0] base, input int n);
    int idx;
    idx = int'((addr - base) >> 2);
    if (addr < base || addr[1:0] != 2'h0 || idx >= n) begin
      return -1;
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Lanes, one controller each
  genvar g;
  generate
    for (g = 0; g < `PZC_LANE_N; g++) begin : gen_lane
      pzc_lane_if lif ();
      // [RULE7] Each lane sees only its own config
      assign lif.cfg = cfg_r[g];
      assign lane_run[g] = (lif.st == PZC_L_RUN);
      pzc_lane u_lane (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .lif(lif),
        .i_init_done(i_init_done),
        .i_cal_trigger(i_cal_trigger),
        .i_common_mdl_en(i_common_mdl_en),
        .i_meas_done(i_meas_done[g]),
        .i_wl_resp(i_wl_resp[g*`PZC_RANK_N +: `PZC_RANK_N]),
        .o_meas_start(o_meas_start[g]),
        .o_mdl_cont(o_mdl_cont[g]),
        .o_wl_done(o_wl_done[g*`PZC_RANK_N +: `PZC_RANK_N]),
        .o_wl_resp(o_wl_resp[g*`PZC_RANK_N +: `PZC_RANK_N])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read decode; no side effects on any read
  always_comb begin
    int s;
    s = 0;
    rd_word = 32'h0000_0000;
    rd_resp = `PZC_RESP_OKAY;
    if (pzc_slot(i_araddr, `PZC_OFS_MAIN_BASE, `PZC_SEG_N) >= 0) begin
      s = pzc_slot(i_araddr, `PZC_OFS_MAIN_BASE, `PZC_SEG_N);
      // [RULE14] Done and error flags
      rd_word[`PZC_MAIN_DONE_BIT] = done_r[s];
      rd_word[`PZC_MAIN_ERR_BIT] = err_r[s];
    end else if (pzc_slot(i_araddr, `PZC_OFS_RES_BASE, `PZC_SEG_N) >= 0) begin
      s = pzc_slot(i_araddr, `PZC_OFS_RES_BASE, `PZC_SEG_N);
      // [RULE5] Upper bits stay zero
      rd_word[`PZC_RES_W-1:0] = res_r[s];
    end else if (pzc_slot(i_araddr, `PZC_OFS_LANE_BASE, `PZC_LANE_N) >= 0) begin
      s = pzc_slot(i_araddr, `PZC_OFS_LANE_BASE, `PZC_LANE_N);
      // [RULE13] Reserved field left zero
      rd_word[`PZC_CFG_SKIP_BIT] = cfg_r[s].auto_period_cal_skip;
      rd_word[`PZC_CFG_MDL_BIT] = cfg_r[s].master_delay_line_enable;
      rd_word[`PZC_CFG_WL_MSB:`PZC_CFG_WL_LSB] = cfg_r[s].wrlvl_rank_enable;
    end else if (i_araddr == `PZC_OFS_INT_STAT) begin
      rd_word[`PZC_INT_W-1:0] = stat_r;
    end else if (i_araddr == `PZC_OFS_INT_MASK) begin
      rd_word[`PZC_INT_W-1:0] = mask_r;
    end else if (i_araddr == `PZC_OFS_LANE_RUN) begin
      rd_word[`PZC_LANE_N-1:0] = lane_run;
    end else begin
      rd_resp = `PZC_RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next values: bus handshakes, status capture, config writes, interrupts
  always_comb begin
    int s;
    s = 0;
    // Write channel: address and data taken in either order, applied once both held
    do_wr = aw_held_r & w_held_r & ~bvalid_r;
    aw_held_nxt = (aw_held_r | (i_awvalid & awready_r)) & ~do_wr;
    w_held_nxt = (w_held_r | (i_wvalid & wready_r)) & ~do_wr;
    aw_addr_nxt = (i_awvalid & awready_r) ? i_awaddr : aw_addr_r;
    w_data_nxt = (i_wvalid & wready_r) ? i_wdata : w_data_r;
    w_strb_nxt = (i_wvalid & wready_r) ? i_wstrb : w_strb_r;
    bvalid_nxt = do_wr | (bvalid_r & ~i_bready);
    awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
    wready_nxt = ~w_held_nxt & ~bvalid_nxt;
    bresp_nxt = bresp_r;
    // Read channel: one outstanding read
    rvalid_nxt = (i_arvalid & arready_r) | (rvalid_r & ~i_rready);
    rdata_nxt = (i_arvalid & arready_r) ? rd_word : rdata_r;
    rresp_nxt = (i_arvalid & arready_r) ? rd_resp : rresp_r;
    rd_addr_nxt = (i_arvalid & arready_r) ? i_araddr : rd_addr_r;
    arready_nxt = ~rvalid_nxt;
    // [RULE6] Four segments sampled every cycle
    // [RULE15] Status tracks the engine, never written
    done_nxt = i_zq_done;
    err_nxt = i_zq_err;
    for (int k = 0; k < `PZC_SEG_N; k++) begin
      // [RULE1] [RULE2] [RULE3] [RULE4] Field order as packed by the engine
      res_nxt[k] = i_zq_state[k*`PZC_RES_W +: `PZC_RES_W];
    end
    for (int k = 0; k < `PZC_LANE_N; k++) begin
      cfg_nxt[k] = cfg_r[k];
    end
    mask_nxt = mask_r;
    w1c = '0;
    if (do_wr) begin
      bresp_nxt = `PZC_RESP_OKAY;
      if (pzc_slot(aw_addr_r, `PZC_OFS_LANE_BASE, `PZC_LANE_N) >= 0) begin
        s = pzc_slot(aw_addr_r, `PZC_OFS_LANE_BASE, `PZC_LANE_N);
        // Only the top byte holds writable lane bits
        if (w_strb_r[3]) begin
          cfg_nxt[s].auto_period_cal_skip = w_data_r[`PZC_CFG_SKIP_BIT];
          cfg_nxt[s].master_delay_line_enable = w_data_r[`PZC_CFG_MDL_BIT];
          // [RULE11] Rank enable per bit
          cfg_nxt[s].wrlvl_rank_enable = w_data_r[`PZC_CFG_WL_MSB:`PZC_CFG_WL_LSB];
        end
      end else if (aw_addr_r == `PZC_OFS_INT_STAT) begin
        w1c = w_strb_r[0] ? w_data_r[`PZC_INT_W-1:0] : '0;
      end else if (aw_addr_r == `PZC_OFS_INT_MASK) begin
        mask_nxt = w_strb_r[0] ? w_data_r[`PZC_INT_W-1:0] : mask_r;
      end else if ((pzc_slot(aw_addr_r, `PZC_OFS_MAIN_BASE, `PZC_SEG_N) < 0)
                   && (pzc_slot(aw_addr_r, `PZC_OFS_RES_BASE, `PZC_SEG_N) < 0)
                   && (aw_addr_r != `PZC_OFS_LANE_RUN)) begin
        // Read-only registers swallow writes quietly; unmapped ones report error
        bresp_nxt = `PZC_RESP_SLVERR;
      end
    end
    // Rising done and error per segment; a new event beats a clear
    ev = '0;
    ev[`PZC_INT_DONE_LSB +: `PZC_SEG_N] = i_zq_done & ~done_r;
    ev[`PZC_INT_ERR_LSB +: `PZC_SEG_N] = i_zq_err & ~err_r;
    stat_nxt = (stat_r & ~w1c) | ev;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  // Registers only
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      done_r <= '0;
      err_r <= '0;
      for (int k = 0; k < `PZC_SEG_N; k++) begin
        res_r[k] <= '0;
      end
      // [RULE8] [RULE9] [RULE11] Documented lane resets
      for (int k = 0; k < `PZC_LANE_N; k++) begin
        cfg_r[k] <= '{`PZC_CFG_SKIP_RST, `PZC_CFG_MDL_RST, `PZC_CFG_WL_RST};
      end
      stat_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= `PZC_RESP_OKAY;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `PZC_RESP_OKAY;
      rd_addr_r <= '0;
    end else begin
      done_r <= done_nxt;
      err_r <= err_nxt;
      res_r <= res_nxt;
      cfg_r <= cfg_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      rd_addr_r <= rd_addr_nxt;
    end
  end

  // Outputs straight from flops
  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_irq = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks on register contents and read data
  AST_RES_TRACKS: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE15]
    1'b1 |=> (res_r[0] == $past(i_zq_state[`PZC_RES_W-1:0]) && done_r == $past(i_zq_done)))
    else $error("status copy does not follow engine");
  AST_RES_UPPER_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE5]
    (rvalid_r && pzc_slot(rd_addr_r, `PZC_OFS_RES_BASE, `PZC_SEG_N) >= 0) |-> (rdata_r[31:`PZC_RES_W] == '0))
    else $error("result upper bits not zero");
  AST_LANE_RSV_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE13]
    (rvalid_r && pzc_slot(rd_addr_r, `PZC_OFS_LANE_BASE, `PZC_LANE_N) >= 0)
      |-> (rdata_r[`PZC_CFG_RSV_MSB:`PZC_CFG_RSV_LSB] == '0))
    else $error("lane reserved bits not zero");
  AST_CFG_RESET: assert property (@(posedge i_sys_clk) // [RULE11]
    $past(i_rst) |-> (cfg_r[0].wrlvl_rank_enable == `PZC_CFG_WL_RST
      && cfg_r[0].master_delay_line_enable && !cfg_r[0].auto_period_cal_skip))
    else $error("lane config reset value wrong");
  AST_MAIN_DONE_READ: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE14]
    (i_arvalid && arready_r && i_araddr == `PZC_OFS_MAIN_BASE) |=> (rdata_r[`PZC_MAIN_DONE_BIT] == $past(done_r[0])))
    else $error("done flag misreported");
endmodule
`default_nettype wire

// ### pzc_defines.svh
// Constants for the impedance status and byte-lane configuration register bank
`ifndef PZC_DEFINES_SVH
`define PZC_DEFINES_SVH
`define PZC_SEG_N 4
`define PZC_LANE_N 9
`define PZC_RANK_N 4
`define PZC_ADDR_W 8
// Register byte offsets
`define PZC_OFS_MAIN_BASE 8'h00
`define PZC_OFS_RES_BASE 8'h10
`define PZC_OFS_LANE_BASE 8'h20
`define PZC_OFS_INT_STAT 8'h44
`define PZC_OFS_INT_MASK 8'h48
`define PZC_OFS_LANE_RUN 8'h4c
// Main status fields
`define PZC_MAIN_DONE_BIT 31
`define PZC_MAIN_ERR_BIT 30
// Result status fields, two bits each
`define PZC_RES_W 8
`define PZC_RES_DPD_LSB 0
`define PZC_RES_DPU_LSB 2
`define PZC_RES_TPD_LSB 4
`define PZC_RES_TPU_LSB 6
// Calibration result codes
`define PZC_CAL_OK 2'h0
`define PZC_CAL_OVF 2'h1
`define PZC_CAL_UNF 2'h2
`define PZC_CAL_BUSY 2'h3
// Lane configuration fields and resets
`define PZC_CFG_SKIP_BIT 31
`define PZC_CFG_MDL_BIT 30
`define PZC_CFG_WL_MSB 29
`define PZC_CFG_WL_LSB 26
`define PZC_CFG_RSV_MSB 25
`define PZC_CFG_RSV_LSB 20
`define PZC_CFG_SKIP_RST 1'b0
`define PZC_CFG_MDL_RST 1'b1
`define PZC_CFG_WL_RST 4'hf
// Interrupt layout: done per segment, then error per segment
`define PZC_INT_W 8
`define PZC_INT_DONE_LSB 0
`define PZC_INT_ERR_LSB 4
// Bus answers
`define PZC_RESP_OKAY 2'h0
`define PZC_RESP_SLVERR 2'h2
`endif

// ### pzc_pkg.sv
// Types shared by the register bank and the lane controller
`default_nettype none
`include "pzc_defines.svh"
package pzc_pkg;
  typedef enum logic [2:0] {
    PZC_L_IDLE = 3'b001,
    PZC_L_INIT = 3'b010,
    PZC_L_RUN = 3'b100
  } pzc_lane_st_t;
  typedef struct packed {
    logic auto_period_cal_skip;
    logic master_delay_line_enable;
    logic [`PZC_RANK_N-1:0] wrlvl_rank_enable;
  } pzc_lane_cfg_t;
endpackage
`default_nettype wire

// ### pzc_lane_if.sv
// Configuration down to one byte lane and its state back up
`timescale 1ns/1ns
`default_nettype none
interface pzc_lane_if;
  import pzc_pkg::*;
  pzc_lane_cfg_t cfg;
  pzc_lane_st_t st;
  modport ctrl (output cfg, input st);
  modport lane (input cfg, output st);
endinterface
`default_nettype wire

// ### pzc_lane.sv
// Per-lane period measurement sequencing and write-leveling rank filtering
`timescale 1ns/1ns
`default_nettype none
module pzc_lane
  import pzc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  pzc_lane_if.lane lif,
  input wire logic i_init_done,
  input wire logic i_cal_trigger,
  input wire logic i_common_mdl_en,
  input wire logic i_meas_done,
  input wire logic [`PZC_RANK_N-1:0] i_wl_resp,
  output logic o_meas_start,
  output logic o_mdl_cont,
  output logic [`PZC_RANK_N-1:0] o_wl_done,
  output logic [`PZC_RANK_N-1:0] o_wl_resp
);
  pzc_lane_st_t st_r, st_nxt;
  logic init_d_r, start_r, start_nxt, cont_r, cont_nxt, init_rise;
  logic [`PZC_RANK_N-1:0] wl_done_r, wl_done_nxt, wl_resp_r, wl_resp_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Next state of the measurement sequencer
  always_comb begin
    init_rise = i_init_done & ~init_d_r;
    st_nxt = st_r;
    start_nxt = 1'b0;
    case (st_r)
      PZC_L_IDLE: begin
        // [RULE8] Skip blocks auto start
        if ((init_rise & ~lif.cfg.auto_period_cal_skip) | i_cal_trigger) begin
          st_nxt = PZC_L_INIT;
          start_nxt = 1'b1;
        end
      end
      PZC_L_INIT: begin
        if (i_meas_done) begin
          st_nxt = PZC_L_RUN;
        end
      end
      PZC_L_RUN: begin
        // [RULE10] Manual retrigger restarts initial measurement
        if (i_cal_trigger) begin
          st_nxt = PZC_L_INIT;
          start_nxt = 1'b1;
        end
      end
      default: st_nxt = PZC_L_IDLE;
    endcase
    // [RULE9] Continue while lane enable held
    // [RULE10] Lane enable ANDed with common
    cont_nxt = (st_nxt == PZC_L_RUN) & lif.cfg.master_delay_line_enable & i_common_mdl_en;
    // [RULE12] Disabled ranks ignored, flagged done
    wl_resp_nxt = i_wl_resp & lif.cfg.wrlvl_rank_enable;
    wl_done_nxt = i_wl_resp | ~lif.cfg.wrlvl_rank_enable;
  end

  // Registers only
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_r <= PZC_L_IDLE;
      init_d_r <= 1'b0;
      start_r <= 1'b0;
      cont_r <= 1'b0;
      wl_done_r <= '0;
      wl_resp_r <= '0;
    end else begin
      st_r <= st_nxt;
      init_d_r <= i_init_done;
      start_r <= start_nxt;
      cont_r <= cont_nxt;
      wl_done_r <= wl_done_nxt;
      wl_resp_r <= wl_resp_nxt;
    end
  end

  assign lif.st = st_r;
  assign o_meas_start = start_r;
  assign o_mdl_cont = cont_r;
  assign o_wl_done = wl_done_r;
  assign o_wl_resp = wl_resp_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the lane outputs
  AST_SKIP_NO_START: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE8]
    (st_r == PZC_L_IDLE && init_rise && lif.cfg.auto_period_cal_skip && !i_cal_trigger) |=> !o_meas_start)
    else $error("auto start despite skip");
  AST_AUTO_START: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE10]
    (st_r == PZC_L_IDLE && init_rise && !lif.cfg.auto_period_cal_skip) |=> (o_meas_start && st_r == PZC_L_INIT))
    else $error("no initial measurement after init");
  AST_CONT_GATED: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE9]
    o_mdl_cont |-> (st_r == PZC_L_RUN && $past(lif.cfg.master_delay_line_enable) && $past(i_common_mdl_en)))
    else $error("continuous measurement without enables");
  AST_WL_MASK: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE12]
    1'b1 |=> (((o_wl_resp & ~$past(lif.cfg.wrlvl_rank_enable)) == '0)
      && ((o_wl_done | $past(lif.cfg.wrlvl_rank_enable)) == '1)))
    else $error("disabled rank not ignored or not done");
endmodule
`default_nettype wire

// ### test_phy_zcal_status_lane_config.sv
// Self-checking bench for the impedance status and byte-lane configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "pzc_defines.svh"
module test_phy_zcal_status_lane_config
  import pzc_pkg::*;
;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, zq_state, seed, v;
  logic [3:0] wstrb, zq_done, zq_err, en;
  logic [1:0] bresp, rresp;
  logic init_done, cal_trig, mdl_en;
  logic [8:0] meas_done, meas_start, mdl_cont, skip, mdl, seen;
  logic [35:0] wl_in, wl_done, wl_resp;
  logic [31:0] cfg [9];
  logic [31:0] exp_q [$];
  int bad_count, n_checks;

  pzc_top pzc_top_i (.i_sys_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_zq_done(zq_done), .i_zq_err(zq_err),
    .i_zq_state(zq_state), .i_init_done(init_done), .i_cal_trigger(cal_trig), .i_common_mdl_en(mdl_en),
    .i_meas_done(meas_done), .i_wl_resp(wl_in), .o_meas_start(meas_start), .o_mdl_cont(mdl_cont),
    .o_wl_done(wl_done), .o_wl_resp(wl_resp), .o_irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Both channels offered together; each dropped at its own take edge
  task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    do begin
      @(posedge clk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 36'(bresp), 36'(er));
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    chk(nm, 36'(rdata), 36'(e));
    chk("rresp", 36'(rresp), 36'(er));
  endtask

  task automatic results();
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'hefad;
    bad_count = 0;
    n_checks = 0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, init_done, cal_trig, mdl_en} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    {zq_done, zq_err, zq_state, meas_done, wl_in} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values of every main, result, lane and mask register
    for (int n = 0; n < 4; n++) begin
      rdchk("main_rst", 8'h00 + 8'(4 * n), 32'h0, `PZC_RESP_OKAY);
      rdchk("res_rst", 8'h10 + 8'(4 * n), 32'h0, `PZC_RESP_OKAY);
    end
    for (int n = 0; n < 9; n++) rdchk("lane_rst", 8'h20 + 8'(4 * n), 32'h7c000000, `PZC_RESP_OKAY);
    rdchk("mask_rst", `PZC_OFS_INT_MASK, 32'h0, `PZC_RESP_OKAY);
    // Interrupt: raise, mask, clear by writing one
    wr32(`PZC_OFS_INT_MASK, 32'h11, `PZC_RESP_OKAY);
    zq_done <= 4'h1;
    repeat (3) @(posedge clk);
    chk("irq_set", 36'(irq), 36'h1);
    rdchk("int_stat", `PZC_OFS_INT_STAT, 32'h01, `PZC_RESP_OKAY);
    wr32(`PZC_OFS_INT_STAT, 32'h01, `PZC_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq_clr", 36'(irq), 36'h0);
    zq_err <= 4'h2;
    repeat (3) @(posedge clk);
    chk("irq_masked", 36'(irq), 36'h0);
    rdchk("int_stat", `PZC_OFS_INT_STAT, 32'h20, `PZC_RESP_OKAY);
    wr32(`PZC_OFS_INT_MASK, 32'h20, `PZC_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq_unmask", 36'(irq), 36'h1);
    wr32(`PZC_OFS_INT_STAT, 32'h20, `PZC_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq_clr2", 36'(irq), 36'h0);
    rdchk("mask_rd", `PZC_OFS_INT_MASK, 32'h20, `PZC_RESP_OKAY);
    for (int k = 0; k < 5; k++) begin
      v = (k < 4) ? {4{2'(k + 3), 2'(k + 2), 2'(k + 1), 2'(k)}} : xs();
      zq_state <= v;
      repeat (2) @(posedge clk);
      // Model of the four result words, queued in segment order
      for (int n = 0; n < 4; n++) exp_q.push_back({24'h0, v[8*n+:8]});
      for (int n = 0; n < 4; n++) rdchk("result", 8'h10 + 8'(4 * n), exp_q.pop_front(), `PZC_RESP_OKAY);
    end
    wr32(8'h10, 32'hffffffff, `PZC_RESP_OKAY);
    wr32(8'h00, 32'hffffffff, `PZC_RESP_OKAY);
    rdchk("res_ro", 8'h10, {24'h0, v[7:0]}, `PZC_RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      v = xs();
      zq_done <= v[3:0];
      zq_err <= v[7:4];
      repeat (2) @(posedge clk);
      for (int n = 0; n < 4; n++) rdchk("main", 8'h00 + 8'(4 * n), {v[n], v[4+n], 30'h0}, `PZC_RESP_OKAY);
    end
    // Unmapped place
    rdchk("unmapped", 8'h50, 32'h0, `PZC_RESP_SLVERR);
    wr32(8'h50, 32'h1, `PZC_RESP_SLVERR);
    for (int n = 0; n < 9; n++) begin
      v = xs();
      v[31] = n[0];
      cfg[n] = v & 32'hfc000000;
      skip[n] = v[31];
      mdl[n] = v[30];
      wr32(8'h20 + 8'(4 * n), v, `PZC_RESP_OKAY);
    end
    for (int n = 0; n < 9; n++) rdchk("lane_cfg", 8'h20 + 8'(4 * n), cfg[n], `PZC_RESP_OKAY);
    // Lane write without top strobe is ignored
    wstrb <= 4'h7;
    wr32(8'h20, 32'h0, `PZC_RESP_OKAY);
    wstrb <= 4'hf;
    rdchk("lane_strb", 8'h20, cfg[0], `PZC_RESP_OKAY);
    wl_in <= 36'({xs(), xs()});
    repeat (3) @(posedge clk);
    for (int n = 0; n < 9; n++) begin
      en = cfg[n][29:26];
      chk("wl_done", 36'(wl_done[4*n+:4]), 36'(4'(wl_in[4*n+:4] | ~en)));
      chk("wl_resp", 36'(wl_resp[4*n+:4]), 36'(4'(wl_in[4*n+:4] & en)));
    end
    mdl_en <= 1'b1;
    init_done <= 1'b1;
    seen = '0;
    repeat (4) begin
      @(posedge clk);
      seen |= meas_start;
    end
    chk("auto_start", 36'(seen), 36'(skip ^ 9'h1ff));
    meas_done <= 9'h1ff;
    repeat (2) @(posedge clk);
    meas_done <= 9'h0;
    repeat (3) @(posedge clk);
    rdchk("lane_run", `PZC_OFS_LANE_RUN, {23'h0, ~skip}, `PZC_RESP_OKAY);
    chk("mdl_cont", 36'(mdl_cont), 36'(~skip & mdl));
    mdl_en <= 1'b0;
    repeat (3) @(posedge clk);
    chk("mdl_off", 36'(mdl_cont), 36'h0);
    cal_trig <= 1'b1;
    seen = '0;
    repeat (4) begin
      @(posedge clk);
      cal_trig <= 1'b0;
      seen |= meas_start;
    end
    chk("trig_start", 36'(seen), 36'h1ff);
    results();
  end
endmodule
`default_nettype wire
